//--- design/ocl_defs.vh
/*
 * Constants for the configuration register bank and its power-on
 * loader: register offsets, reset values, field positions, memory
 * layout and timing counts. Included by the loader and bank modules.
 */
// How it works
// - memory bit address is page times 128 plus byte times 8 plus bit
// - a page is valid only with marker 0xa5 and a correct checksum
// - bytes 0x0 to 0xa, checksum included, sum to zero modulo 256
// - an invalid page loads nothing; its registers keep their earlier values
// - status at 0x20: factory marker, factory sum, user found, user sum, temperature
// - validity bits captured once at load; temperature bit refreshed continuously
// - temperature flag follows threshold chosen by global config bits 7:5
// - global config bits 0-4: vertical, ext coil, ratiometric, hall rev, coil rev
// - hall config bits 1:0 set spin period 200/400/600/800 ns, reset 01
// - hall bits 2 and 3 set reset and integration pulse, 50 or 100 ns
// - hall bit 4 low masks each cycle for 50 ns; resets to 1
// - hall bit 5 selects fast mode; bits 7:6 unused
// - filter bits 1:0 select 5k, 10k or 20k low-pass; reset 01
// - filter bits 2,3,4: 160k hall low-pass, coil path off, coil high-pass off
// - filter bits 6:5 select high-pass corner, reset code 3
// - oscillator trim 8 to 32 MHz in 100 kHz steps, reset 0x80
// - oscillator drift: low nibble up to 40 C, high nibble above; reset 0xaa
// - coarse offset bits 6:0 level, bit 7 selects half supply; reset 0x20
// - offset drift and fine offset: bits 6:0 magnitude, bit 7 polarity
// - host reaches registers with 6-bit addresses over the single-wire link
`ifndef OCL_DEFS_VH
`define OCL_DEFS_VH

// ************************************************************
// register offsets
// ************************************************************
`define OCL_OFS_GAIN_COARSE    6'h00
`define OCL_OFS_GAIN_FINE      6'h01
`define OCL_OFS_GAIN_DRIFT     6'h02
`define OCL_OFS_OFFSET_COARSE  6'h03
`define OCL_OFS_OFFSET_FINE    6'h04
`define OCL_OFS_OFFSET_DRIFT   6'h05
`define OCL_OFS_GLOBAL_CFG     6'h10
`define OCL_OFS_HALL_CFG       6'h11
`define OCL_OFS_HALL_BIAS      6'h12
`define OCL_OFS_COIL_GAIN      6'h13
`define OCL_OFS_FILTER_CFG     6'h14
`define OCL_OFS_OSC_TRIM       6'h15
`define OCL_OFS_OSC_DRIFT      6'h16
`define OCL_OFS_LOT_BASE       6'h17
`define OCL_OFS_STATUS         6'h20

// ************************************************************
// reset values
// ************************************************************
`define OCL_RST_GAIN_COARSE    8'h04
`define OCL_RST_GAIN_FINE      8'h80
`define OCL_RST_OFFSET_COARSE  8'h20
`define OCL_RST_HALL_CFG       8'h11
`define OCL_RST_HALL_BIAS      8'h70
`define OCL_RST_COIL_GAIN      8'h77
`define OCL_RST_FILTER_CFG     8'h61
`define OCL_RST_OSC_TRIM       8'h80
`define OCL_RST_OSC_DRIFT      8'haa

// ************************************************************
// memory layout
// ************************************************************
`define OCL_PAGE_MARKER        8'ha5
`define OCL_PAGE_BYTES         4'hb
`define OCL_BYTE_MARKER        4'h9
`define OCL_BYTE_SUM           4'ha
`define OCL_USER_BYTES         4'h9
`define OCL_FACT_CFG_BYTES     4'h7
`define OCL_FACTORY_PAGE       3'h4

// ************************************************************
// timing: figures in ns, counts at the 4 ns clock
// ************************************************************
`define OCL_CLK_NS             4
`define OCL_SPIN_UNIT_NS       200
`define OCL_PULSE_SHORT_NS     50
`define OCL_PULSE_LONG_NS      100
`define OCL_SPIN_UNIT_CYC      (`OCL_SPIN_UNIT_NS / `OCL_CLK_NS)
`define OCL_PULSE_SHORT_CYC    ((`OCL_PULSE_SHORT_NS + `OCL_CLK_NS - 1) / `OCL_CLK_NS)
`define OCL_PULSE_LONG_CYC     ((`OCL_PULSE_LONG_NS + `OCL_CLK_NS - 1) / `OCL_CLK_NS)

`endif

//--- design/ocl_regs.v
/*
 * Configuration register bank with power-on loader from one-time
 * programmable memory, status register and hall spin timing.
 * Assumes the single-wire link decoder outside presents one register
 * access at a time, and the memory answers byte reads on this clock.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ocl_defs.vh"

module ocl_regs (
	input  wire       i_mclk,
	input  wire       i_rst_n,
	input  wire       i_reg_wr,
	input  wire       i_reg_rd,
	input  wire [5:0] i_reg_addr,
	input  wire [7:0] i_reg_wdata,
	output wire [7:0] o_reg_rdata,
	output wire       o_reg_rvalid,
	output wire       o_otp_rd,
	output wire [9:0] o_otp_addr,
	input  wire       i_otp_ack,
	input  wire [7:0] i_otp_rdata,
	input  wire [8:0] i_temp_over,
	output wire       o_load_done,
	output wire [7:0] o_gain_coarse,
	output wire [7:0] o_gain_fine,
	output wire [7:0] o_gain_drift_comp,
	output wire [6:0] o_offset_coarse_level,
	output wire       o_offset_half_supply,
	output wire [7:0] o_offset_fine_level,
	output wire [7:0] o_offset_drift_comp,
	output wire       o_vertical_axis,
	output wire       o_ext_coil,
	output wire       o_ratiometric,
	output wire       o_hall_rev,
	output wire       o_coil_rev,
	output wire [7:0] o_hall_bias_level,
	output wire [7:0] o_coil_gain,
	output wire [1:0] o_lp_corner,
	output wire       o_hall_lp_160k,
	output wire       o_coil_path_off,
	output wire       o_coil_hp_off,
	output wire [1:0] o_hp_corner,
	output wire [7:0] o_osc_freq_trim,
	output wire [3:0] o_osc_drift_active,
	output wire       o_amp_reset,
	output wire       o_rect_integ,
	output wire       o_meas_mask,
	output wire       o_fast_mode
);

	// ************************************************************
	// loader states
	// ************************************************************
	localparam [2:0] LD_REQ  = 3'h0;
	localparam [2:0] LD_WAIT = 3'h1;
	localparam [2:0] LD_EVAL = 3'h2;
	localparam [2:0] LD_DONE = 3'h3;

	localparam [7:0] SPIN_UNIT   = `OCL_SPIN_UNIT_CYC;
	localparam [7:0] PULSE_SHORT = `OCL_PULSE_SHORT_CYC;
	localparam [7:0] PULSE_LONG  = `OCL_PULSE_LONG_CYC;

	integer i;

	reg [7:0] cfg_q [0:31];
	reg [7:0] buf_q [0:10];
	reg [2:0] ld_state_q;
	reg [2:0] page_q;
	reg [3:0] byte_q;
	reg [7:0] sum_q;
	reg       otp_rd_q;
	reg [9:0] otp_addr_q;
	reg [3:0] stat_q;
	reg       temp_flag_q;
	reg [7:0] rdata_q;
	reg       rvalid_q;
	reg [1:0] lp_q;
	reg [3:0] drift_sel_q;
	reg [7:0] spin_cnt_q;
	reg       amp_q;
	reg       integ_q;
	reg       mask_q;
	reg       done_q;
	wire [8:0] temp_sync;
	wire       page_ok;
	wire       user_page;
	wire [7:0] spin_period;
	wire [7:0] amp_w;
	wire [7:0] integ_w;

	// reset default of each bank entry
	function [7:0] rst_val;
		input [4:0] a;
		begin
			case (a)
				5'h00:   rst_val = `OCL_RST_GAIN_COARSE;
				5'h01:   rst_val = `OCL_RST_GAIN_FINE;
				5'h03:   rst_val = `OCL_RST_OFFSET_COARSE;
				5'h11:   rst_val = `OCL_RST_HALL_CFG;
				5'h12:   rst_val = `OCL_RST_HALL_BIAS;
				5'h13:   rst_val = `OCL_RST_COIL_GAIN;
				5'h14:   rst_val = `OCL_RST_FILTER_CFG;
				5'h15:   rst_val = `OCL_RST_OSC_TRIM;
				5'h16:   rst_val = `OCL_RST_OSC_DRIFT;
				default: rst_val = 8'h00;
			endcase
		end
	endfunction

	// ************************************************************
	// temperature comparator inputs
	// ************************************************************
	ocl_sync #(
		.W(9)
	) u_temp_sync (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_async (i_temp_over),
		.o_sync  (temp_sync)
	);

	// ************************************************************
	// power-on loader
	// ************************************************************
	// checksum over bytes 0x0..0xa, checksum included
	assign page_ok   = (buf_q[`OCL_BYTE_MARKER] == `OCL_PAGE_MARKER) &&
	                   (sum_q == 8'h00);
	assign user_page = (page_q != `OCL_FACTORY_PAGE);

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ld_state_q <= LD_REQ;
			page_q     <= 3'h0;
			byte_q     <= 4'h0;
			sum_q      <= 8'h00;
			otp_rd_q   <= 1'b0;
			otp_addr_q <= 10'h000;
			stat_q     <= 4'h0;
			done_q     <= 1'b0;
			for (i = 0; i < 11; i = i + 1) begin
				buf_q[i] <= 8'h00;
			end
		end else begin
			otp_rd_q <= 1'b0;
			case (ld_state_q)
				LD_REQ: begin
					otp_rd_q   <= 1'b1;
					otp_addr_q <= {page_q, byte_q, 3'h0};
					ld_state_q <= LD_WAIT;
				end
				LD_WAIT: begin
					if (i_otp_ack) begin
						buf_q[byte_q] <= i_otp_rdata;
						sum_q         <= sum_q + i_otp_rdata;
						if (byte_q == `OCL_BYTE_SUM) begin
							ld_state_q <= LD_EVAL;
						end else begin
							byte_q     <= byte_q + 4'h1;
							ld_state_q <= LD_REQ;
						end
					end
				end
				LD_EVAL: begin
					// validity bits are only ever set here
					if (user_page) begin
						if (sum_q == 8'h00) begin
							stat_q[3] <= 1'b1;
						end
						if (page_ok) begin
							stat_q[2] <= 1'b1;
						end
					end else begin
						stat_q[0] <= (buf_q[`OCL_BYTE_MARKER] == `OCL_PAGE_MARKER);
						stat_q[1] <= (sum_q == 8'h00);
					end
					byte_q <= 4'h0;
					sum_q  <= 8'h00;
					if (user_page) begin
						page_q     <= page_q + 3'h1;
						ld_state_q <= LD_REQ;
					end else begin
						ld_state_q <= LD_DONE;
						done_q     <= 1'b1;
					end
				end
				LD_DONE: begin
					ld_state_q <= LD_DONE;
				end
				default: begin
					ld_state_q <= LD_DONE;
				end
			endcase
		end
	end

	// ************************************************************
	// register bank: reset, load commit, host writes
	// ************************************************************
	// host writes are dropped while loading so a load never races them
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (i = 0; i < 32; i = i + 1) begin
				cfg_q[i] <= rst_val(i[4:0]);
			end
		end else if (ld_state_q == LD_EVAL) begin
			if (page_ok && user_page) begin
				// later pages overwrite earlier ones
				for (i = 0; i < 9; i = i + 1) begin
					cfg_q[i] <= buf_q[i];
				end
			end else if (page_ok) begin
				for (i = 0; i < 7; i = i + 1) begin
					cfg_q[16 + i] <= buf_q[i];
				end
				cfg_q[23] <= buf_q[7];
				cfg_q[24] <= buf_q[8];
			end
			// an invalid page leaves the bank untouched
		end else if (ld_state_q == LD_DONE && i_reg_wr && !i_reg_addr[5]) begin
			cfg_q[i_reg_addr[4:0]] <= i_reg_wdata;
		end
	end

	// ************************************************************
	// status and host reads
	// ************************************************************
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			temp_flag_q <= 1'b0;
			rdata_q     <= 8'h00;
			rvalid_q    <= 1'b0;
		end else begin
			temp_flag_q <= temp_sync[cfg_q[16][7:5]];
			rvalid_q    <= i_reg_rd;
			if (i_reg_rd) begin
				if (!i_reg_addr[5]) begin
					rdata_q <= cfg_q[i_reg_addr[4:0]];
				end else if (i_reg_addr == `OCL_OFS_STATUS) begin
					rdata_q <= {3'h0, temp_flag_q, stat_q};
				end else begin
					rdata_q <= 8'h00;
				end
			end
		end
	end

	// ************************************************************
	// decoded settings
	// ************************************************************
	// code 11 has no corner; it falls back to the reset corner
	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lp_q        <= 2'h1;
			drift_sel_q <= 4'ha;
		end else begin
			lp_q        <= (cfg_q[20][1:0] == 2'h3) ? 2'h1 : cfg_q[20][1:0];
			drift_sel_q <= temp_sync[8] ? cfg_q[22][7:4] : cfg_q[22][3:0];
		end
	end

	// ************************************************************
	// hall spin timing
	// ************************************************************
	assign spin_period = SPIN_UNIT * {6'h00, cfg_q[17][1:0]} + SPIN_UNIT;
	assign amp_w       = cfg_q[17][2] ? PULSE_LONG : PULSE_SHORT;
	assign integ_w     = cfg_q[17][3] ? PULSE_LONG : PULSE_SHORT;

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			spin_cnt_q <= 8'h00;
			amp_q      <= 1'b0;
			integ_q    <= 1'b0;
			mask_q     <= 1'b0;
		end else begin
			if (spin_cnt_q >= spin_period - 8'h01) begin
				spin_cnt_q <= 8'h00;
			end else begin
				spin_cnt_q <= spin_cnt_q + 8'h01;
			end
			amp_q   <= (spin_cnt_q < amp_w);
			integ_q <= (spin_cnt_q >= spin_period - integ_w);
			// enable taken at cycle start only, so a write never cuts a mask short
			if (spin_cnt_q == 8'h00) begin
				mask_q <= !cfg_q[17][4];
			end else begin
				mask_q <= mask_q && (spin_cnt_q < PULSE_SHORT);
			end
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_reg_rdata           = rdata_q;
	assign o_reg_rvalid          = rvalid_q;
	assign o_otp_rd              = otp_rd_q;
	assign o_otp_addr            = otp_addr_q;
	assign o_load_done           = done_q;
	assign o_gain_coarse         = cfg_q[0];
	assign o_gain_fine           = cfg_q[1];
	assign o_gain_drift_comp     = cfg_q[2];
	assign o_offset_coarse_level = cfg_q[3][6:0];
	assign o_offset_half_supply  = cfg_q[3][7];
	assign o_offset_fine_level   = cfg_q[4];
	assign o_offset_drift_comp   = cfg_q[5];
	assign o_vertical_axis       = cfg_q[16][0];
	assign o_ext_coil            = cfg_q[16][1];
	assign o_ratiometric         = cfg_q[16][2];
	assign o_hall_rev            = cfg_q[16][3];
	assign o_coil_rev            = cfg_q[16][4];
	assign o_hall_bias_level     = cfg_q[18];
	assign o_coil_gain           = cfg_q[19];
	assign o_lp_corner           = lp_q;
	assign o_hall_lp_160k        = cfg_q[20][2];
	assign o_coil_path_off       = cfg_q[20][3];
	assign o_coil_hp_off         = cfg_q[20][4];
	assign o_hp_corner           = cfg_q[20][6:5];
	assign o_osc_freq_trim       = cfg_q[21];
	assign o_osc_drift_active    = drift_sel_q;
	assign o_amp_reset           = amp_q;
	assign o_rect_integ          = integ_q;
	assign o_meas_mask           = mask_q;
	assign o_fast_mode           = cfg_q[17][5];

endmodule // ocl_regs

`default_nettype wire

//--- design/ocl_sync.v
/*
 * Three-stage input synchroniser for a vector of pin levels.
 * Assumes each bit is an unrelated slow level; no bus coherence.
 */
`timescale 1ns/100ps
`default_nettype none

module ocl_sync #(
	parameter W = 1
) (
	input  wire         i_mclk,
	input  wire         i_rst_n,
	input  wire [W-1:0] i_async,
	output wire [W-1:0] o_sync
);

	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;
	reg [W-1:0] out_q;
	wire [W-1:0] agree;

	// a bit only moves once stages two and three agree
	assign agree = ~(s2_q ^ s3_q);

	always @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s1_q  <= {W{1'b0}};
			s2_q  <= {W{1'b0}};
			s3_q  <= {W{1'b0}};
			out_q <= {W{1'b0}};
		end else begin
			s1_q  <= i_async;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			out_q <= (s2_q & agree) | (out_q & ~agree);
		end
	end

	assign o_sync = out_q;

endmodule // ocl_sync

`default_nettype wire

//--- tb/ocl_otp_model.sv
/*
 * behavioural one-time-programmable memory that answers loader byte reads.
 * assumes the loader holds the address until the answer strobe arrives.
 */
`timescale 1ns/100ps
`default_nettype none

module ocl_otp_model (
	input  wire logic       i_mclk,
	input  wire logic       i_rd,
	input  wire logic [9:0] i_addr,
	input  wire logic       i_slow,
	output logic            o_ack,
	output logic [7:0]      o_rdata
);
	// ********
	// page store: five pages of eleven bytes
	// ********
	logic [7:0] mem [0:54];
	logic [7:0] last = 8'h00;
	int         idx;

	initial o_ack = 1'b0;
	initial o_rdata = 8'hff;

	always @(posedge i_mclk) begin
		o_ack <= 1'b0;
		// idle bus shows the inverse, so a stale byte never looks valid
		o_rdata <= ~last;
		if (i_rd) begin
			if (i_slow)
				repeat (3) @(posedge i_mclk);
			idx = int'(i_addr[9:7]) * 11 + int'(i_addr[6:3]);
			o_ack <= 1'b1;
			o_rdata <= mem[idx];
			last <= mem[idx];
		end
	end
endmodule // ocl_otp_model
`default_nettype wire

//--- tb/ocl_regs_assertions.sv
/*
 * concurrent checks on the register bank and loader ports.
 * assumes one clock domain with an active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none

module ocl_regs_assertions (
	input wire logic       i_mclk,
	input wire logic       i_rst_n,
	input wire logic       i_reg_rd,
	input wire logic [5:0] i_reg_addr,
	input wire logic [7:0] o_reg_rdata,
	input wire logic       o_reg_rvalid,
	input wire logic       o_otp_rd,
	input wire logic [9:0] o_otp_addr,
	input wire logic       o_load_done,
	input wire logic       o_amp_reset,
	input wire logic       o_rect_integ,
	input wire logic       o_meas_mask
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	// 50 ns at a 4 ns clock rounds up to thirteen cycles
	sequence hi13_s(s);
		s[*8] ##1 s[*5];
	endsequence

	read_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
		else $error("read strobe not answered next cycle");
	rvalid_cause_a: assert property (o_reg_rvalid |-> $past(i_reg_rd))
		else $error("read answer without a read");
	status_res_a: assert property (
		o_reg_rvalid && $past(i_reg_addr) == 6'h20 |-> o_reg_rdata[7:5] == 3'h0)
		else $error("status reserved bits not zero");
	high_addr_a: assert property (
		o_reg_rvalid && $past(i_reg_addr) > 6'h20 |-> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	otp_addr_form_a: assert property (o_otp_rd |-> o_otp_addr[2:0] == 3'h0 &&
		o_otp_addr[6:3] <= 4'ha && o_otp_addr[9:7] <= 3'h4)
		else $error("memory address outside page layout");
	otp_step_a: assert property (
		o_otp_rd && o_otp_addr[6:3] != 4'h0 |-> $past(o_otp_addr) == o_otp_addr - 10'h8)
		else $error("memory bytes not fetched in order");
	load_hold_a: assert property (o_load_done |=> o_load_done)
		else $error("load done dropped");
	no_refetch_a: assert property (o_load_done |-> !o_otp_rd)
		else $error("memory read after loading");
	amp_pulse_a: assert property ($rose(o_amp_reset) |-> hi13_s(o_amp_reset))
		else $error("amplifier reset pulse too short");
	integ_pulse_a: assert property ($rose(o_rect_integ) |-> hi13_s(o_rect_integ))
		else $error("integration pulse too short");
	mask_pulse_a: assert property (
		$rose(o_meas_mask) |-> hi13_s(o_meas_mask) ##1 !o_meas_mask)
		else $error("mask pulse not one 50 ns clock");
endmodule // ocl_regs_assertions

bind ocl_regs ocl_regs_assertions u_chk (.i_mclk, .i_rst_n, .i_reg_rd, .i_reg_addr,
	.o_reg_rdata, .o_reg_rvalid, .o_otp_rd, .o_otp_addr, .o_load_done, .o_amp_reset,
	.o_rect_integ, .o_meas_mask);
`default_nettype wire

//--- tb/tb_ocl_regs.sv
/*
 * self-checking bench for the register bank and its power-on loader.
 * assumes the memory model answers on the same clock as the bank.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
	$display("CHECK FAILED %s exp %h got %h", nm, e, g); end end

module tb_ocl_regs;
	logic       i_mclk = 0, i_rst_n = 0, i_reg_wr = 0, i_reg_rd = 0, slow = 0;
	logic [5:0] i_reg_addr = 0;
	logic [7:0] i_reg_wdata = 0, o_reg_rdata, i_otp_rdata;
	logic [8:0] i_temp_over = 0;
	logic [9:0] o_otp_addr;
	logic [6:0] o_offset_coarse_level;
	logic [3:0] o_osc_drift_active;
	logic [1:0] o_lp_corner, o_hp_corner;
	logic       o_reg_rvalid, o_otp_rd, i_otp_ack, o_load_done, o_offset_half_supply;
	logic       o_vertical_axis, o_ext_coil, o_ratiometric, o_hall_rev, o_coil_rev;
	logic       o_hall_lp_160k, o_coil_path_off, o_coil_hp_off;
	int         bad_count = 0, checks_done = 0;
	logic [5:0] dfa [14] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h10, 6'h11,
		6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h20};
	logic [7:0] dfv [14] = '{8'h04, 8'h80, 8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h11,
		8'h70, 8'h77, 8'h61, 8'h80, 8'haa, 8'h0a};

	ocl_regs u_dut (.i_mclk, .i_rst_n, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
		.o_reg_rdata, .o_reg_rvalid, .o_otp_rd, .o_otp_addr, .i_otp_ack, .i_otp_rdata,
		.i_temp_over, .o_load_done, .o_gain_coarse(), .o_gain_fine(), .o_gain_drift_comp(),
		.o_offset_coarse_level, .o_offset_half_supply, .o_offset_fine_level(),
		.o_offset_drift_comp(), .o_vertical_axis, .o_ext_coil, .o_ratiometric, .o_hall_rev,
		.o_coil_rev, .o_hall_bias_level(), .o_coil_gain(), .o_lp_corner, .o_hall_lp_160k,
		.o_coil_path_off, .o_coil_hp_off, .o_hp_corner, .o_osc_freq_trim(),
		.o_osc_drift_active, .o_amp_reset(), .o_rect_integ(), .o_meas_mask(), .o_fast_mode());
	ocl_otp_model u_otp (.i_mclk, .i_rd(o_otp_rd), .i_addr(o_otp_addr), .i_slow(slow),
		.o_ack(i_otp_ack), .o_rdata(i_otp_rdata));

	always #2 i_mclk = ~i_mclk;

	// ********
	// access tasks
	// ********
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(posedge i_mclk);
		#1 i_reg_rd = 1;
		i_reg_addr = a;
		@(posedge i_mclk);
		#1 i_reg_rd = 0;
		`CHK("rvalid", 1'b1, o_reg_rvalid)
		`CHK($sformatf("reg %h", a), e, o_reg_rdata)
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		#1 i_reg_wr = 1;
		i_reg_addr = a;
		i_reg_wdata = v;
		@(posedge i_mclk);
		#1 i_reg_wr = 0;
	endtask

	task automatic pg(input int p, input logic [7:0] b, mk, bad);
		logic [7:0] s;
		s = mk;
		for (int i = 0; i < 9; i++) begin
			u_otp.mem[p*11+i] = b + 8'(i);
			s += b + 8'(i);
		end
		u_otp.mem[p*11+9] = mk;
		u_otp.mem[p*11+10] = bad - s;
	endtask

	task automatic boot(input logic sl);
		@(posedge i_mclk);
		#1 slow = sl;
		i_rst_n = 0;
		repeat (2) @(posedge i_mclk);
		#1 i_rst_n = 1;
	endtask

	task automatic wait_load;
		for (int n = 0; n < 3000 && o_load_done !== 1'b1; n++)
			@(posedge i_mclk);
		`CHK("load_done", 1'b1, o_load_done)
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ********
	// tests
	// ********
	initial begin
		for (int i = 0; i < 55; i++)
			u_otp.mem[i] = 8'h00;
		boot(0);
		wait_load;
		for (int i = 0; i < 14; i++) rd(dfa[i], dfv[i]);
		$display("test blank memory done");
		pg(0, 8'h10, 8'ha5, 8'h01);
		pg(1, 8'h30, 8'ha5, 8'h00);
		pg(2, 8'h50, 8'h5a, 8'h00);
		pg(3, 8'h70, 8'ha5, 8'h00);
		pg(4, 8'h01, 8'ha5, 8'h00);
		boot(1);
		// a write while loading must be dropped
		wr(6'h09, 8'h99);
		wait_load;
		for (int i = 0; i < 9; i++) rd(6'(i), 8'h70 + 8'(i));
		for (int i = 0; i < 9; i++) rd(6'h10 + 6'(i), 8'h01 + 8'(i));
		rd(6'h09, 8'h00);
		rd(6'h20, 8'h0f);
		$display("test page load done");
		wr(6'h14, 8'h7e);
		rd(6'h14, 8'h7e);
		`CHK("filter pins", 7'h7e, {o_hp_corner, o_coil_hp_off, o_coil_path_off, o_hall_lp_160k, o_lp_corner})
		wr(6'h10, 8'h75);
		rd(6'h10, 8'h75);
		`CHK("global pins", 5'h15, {o_coil_rev, o_hall_rev, o_ratiometric, o_ext_coil, o_vertical_axis})
		wr(6'h03, 8'hc5);
		rd(6'h03, 8'hc5);
		`CHK("offset pins", 8'hc5, {o_offset_half_supply, o_offset_coarse_level})
		wr(6'h20, 8'hff);
		rd(6'h20, 8'h0f);
		rd(6'h21, 8'h00);
		i_temp_over = 9'h008;
		repeat (10) @(posedge i_mclk);
		rd(6'h20, 8'h1f);
		i_temp_over = 9'h100;
		repeat (10) @(posedge i_mclk);
		rd(6'h20, 8'h0f);
		`CHK("drift nibble", 4'h0, o_osc_drift_active)
		i_temp_over = 9'h000;
		repeat (10) @(posedge i_mclk);
		`CHK("drift nibble", 4'h7, o_osc_drift_active)
		wr(6'h11, 8'h01);
		repeat (220) @(posedge i_mclk);
		rd(6'h11, 8'h01);
		$display("test register access done");
		give_verdict;
	end

	initial begin
		#100000;
		bad_count++;
		$display("watchdog expired");
		give_verdict;
	end
endmodule // tb_ocl_regs
`default_nettype wire
